// ---- src/crc_clock_ratio_control.v ----
// apb-controlled clock ratio control: frequency control register, straps, dividers, stabilization wait
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "crc_defines.vh"
// Contract
// - frequency control is 16 bits, word access only
// - register loaded only at power-on reset
// - strap pins select mode and initial value
// - halving divider set only by mode
// - pll1 factor set only by mode
// - bits 15-12 read zero, write zero
// - bit 11 enables bus clock pin output
// - disabled pin keeps internal frequency running
// - no pull-up during hardware standby
// - bit 10 enables pll1, resets one except in mode 6 (zero)
// - bit 9 enables pll2, resets one except in mode 6 (zero)
// - cpu ratio bits 8-6, six codes
// - bus ratio bits 5-3, six codes
// - peripheral ratio bits 2-0, five codes
// - ratios divide mode-chosen reference clock
// - cpu or peripheral change is immediate
// - pll1 enable halts clock until overflow
// - bus change waits only when pll2 on
module crc_clock_ratio_control (
  // clock and reset
  input wire clock,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // straps, reference and standby
  input wire [2:0] mode_strap_pins,
  input wire input_clock_en,
  input wire pll1_out_en,
  input wire hw_standby,
  // bus clock output pin
  output reg bus_clock_output_pin_o,
  output reg bus_clock_output_pin_oe_n,
  output reg bus_clock_pullup_en,
  // clock enables and status
  output wire cpu_clock_en,
  output wire bus_clock_en,
  output wire periph_clock_en,
  output reg pll1_on,
  output reg pll2_on,
  output reg internal_halt,
  output reg halving_divider_on,
  output reg pll1_mult_x12
);
  localparam ST_RUN = 2'h0;
  localparam ST_WAIT1 = 2'h1;
  localparam ST_WAIT2 = 2'h2;

  reg [15:0] frequency_control_reg;
  reg [15:0] stab_count_reg;
  reg [15:0] watchdog_timer_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [3:0] por_cnt_reg;
  reg strap_loaded_reg;
  reg [31:0] prdata_reg;
  reg bus_half_reg;
  wire [15:0] init_value;
  wire halve_input;
  wire pll1_x12;
  wire ref_en;
  wire bus_tick;

  function [15:0] sanitize;
    input [15:0] v;
    begin
      sanitize = v & `CRC_RSVD_MASK;
    end
  endfunction

  crc_mode_decode u_decode (
    .mode(mode_strap_pins),
    .init_value(init_value),
    .halve_input(halve_input),
    .pll1_x12(pll1_x12)
  );

  // apb decode: word write needs low halfword strobes; anything else is an error
  wire access = psel && penable;
  wire hit_freq = (paddr == `CRC_FREQ_CTRL_ADDR);
  wire hit_stab = (paddr == `CRC_STAB_CFG_ADDR);
  wire hit_stat = (paddr == `CRC_CLK_STAT_ADDR);
  wire size_ok = !pwrite || (pstrb[1:0] == 2'h3);
  wire hit_any = hit_freq || hit_stab || hit_stat;
  wire wr_freq = access && pwrite && hit_freq && size_ok;
  wire wr_stab = access && pwrite && hit_stab && size_ok;
  wire [15:0] new_val = sanitize(pwdata[15:0]);
  wire bus_changed = new_val[`CRC_BUS_HI:`CRC_BUS_LO] != frequency_control_reg[`CRC_BUS_HI:`CRC_BUS_LO];
  wire pll1_rise = new_val[`CRC_PLL1_BIT] && !frequency_control_reg[`CRC_PLL1_BIT];
  wire wdt_over = (watchdog_timer_reg == 16'hFFFF);

  assign pready = 1'b1;
  assign pslverr = access && (!hit_any || !size_ok || (pwrite && hit_stat));
  assign prdata = prdata_reg;

  // register loads from straps only after the power-on reset releases
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      por_cnt_reg <= 4'h0;
      strap_loaded_reg <= 1'b0;
      frequency_control_reg <= 16'h0000;
      halving_divider_on <= 1'b0;
      pll1_mult_x12 <= 1'b0;
    end else if (!strap_loaded_reg) begin
      if (por_cnt_reg == `CRC_POR_CYCLES) begin
        strap_loaded_reg <= 1'b1;
        frequency_control_reg <= init_value;
        halving_divider_on <= halve_input;
        pll1_mult_x12 <= pll1_x12;
      end else begin
        por_cnt_reg <= por_cnt_reg + 4'h1;
      end
    end else if (wr_freq && state_reg == ST_RUN) begin
      frequency_control_reg <= new_val;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      stab_count_reg <= `CRC_STAB_DEFAULT;
    end else if (wr_stab) begin
      stab_count_reg <= pwdata[15:0];
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `CRC_FREQ_CTRL_ADDR) begin
        prdata_reg <= {16'h0000, sanitize(frequency_control_reg)};
      end else if (paddr == `CRC_STAB_CFG_ADDR) begin
        prdata_reg <= {16'h0000, stab_count_reg};
      end else if (paddr == `CRC_CLK_STAT_ADDR) begin
        prdata_reg <= {26'h000_0000, halving_divider_on, pll1_mult_x12, pll1_on, pll2_on,
                       internal_halt, strap_loaded_reg};
      end else begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  // stabilization wait: one period for pll1 alone, a second when pll2 is on
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (wr_freq && strap_loaded_reg) begin
          if (pll1_rise) begin
            state_next = ST_WAIT1;
          end else if (bus_changed && new_val[`CRC_PLL2_BIT]) begin
            state_next = ST_WAIT2;
          end
        end
      end
      ST_WAIT1: begin
        if (wdt_over) begin
          state_next = frequency_control_reg[`CRC_PLL2_BIT] ? ST_WAIT2 : ST_RUN;
        end
      end
      ST_WAIT2: begin
        if (wdt_over) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_RUN;
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= ST_RUN;
      watchdog_timer_reg <= 16'h0000;
      internal_halt <= 1'b0;
    end else begin
      state_reg <= state_next;
      internal_halt <= (state_next != ST_RUN);
      // counter reloads on overflow and while running; it counts up through each wait period
      if (state_reg == ST_RUN || wdt_over) begin
        watchdog_timer_reg <= stab_count_reg;
      end else begin
        watchdog_timer_reg <= watchdog_timer_reg + 16'h0001;
      end
    end
  end

  // reference: halved input, raw input or pll1 output
  reg half_phase_reg;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      half_phase_reg <= 1'b0;
    end else if (input_clock_en) begin
      half_phase_reg <= ~half_phase_reg;
    end
  end
  assign ref_en = frequency_control_reg[`CRC_PLL1_BIT] ? pll1_out_en :
                  (halving_divider_on ? (input_clock_en && half_phase_reg) : input_clock_en);

  // clocks stop during a wait but not when the pin is disabled
  wire run = strap_loaded_reg && !internal_halt;

  crc_ratio_divider u_cpu (
    .clock(clock),
    .rst(rst),
    .ref_en(ref_en),
    .code(frequency_control_reg[`CRC_CPU_HI:`CRC_CPU_LO]),
    .offset_half(1'b0),
    .run(run),
    .tick(cpu_clock_en)
  );
  crc_ratio_divider u_bus (
    .clock(clock),
    .rst(rst),
    .ref_en(ref_en),
    .code(frequency_control_reg[`CRC_BUS_HI:`CRC_BUS_LO]),
    .offset_half(1'b0),
    .run(run),
    .tick(bus_tick)
  );
  crc_ratio_divider u_per (
    .clock(clock),
    .rst(rst),
    .ref_en(ref_en),
    .code(frequency_control_reg[`CRC_PER_HI:`CRC_PER_LO]),
    .offset_half(1'b1),
    .run(run),
    .tick(periph_clock_en)
  );
  assign bus_clock_en = bus_tick;

  // pin toggles at each bus tick; high impedance when disabled, with pull-up outside hardware standby
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_half_reg <= 1'b0;
      bus_clock_output_pin_o <= 1'b0;
      bus_clock_output_pin_oe_n <= 1'b1;
      bus_clock_pullup_en <= 1'b0;
      pll1_on <= 1'b0;
      pll2_on <= 1'b0;
    end else begin
      if (bus_tick) begin
        bus_half_reg <= ~bus_half_reg;
      end
      bus_clock_output_pin_o <= bus_half_reg;
      bus_clock_output_pin_oe_n <= !(strap_loaded_reg && frequency_control_reg[`CRC_CKOE_BIT]);
      bus_clock_pullup_en <= strap_loaded_reg && !frequency_control_reg[`CRC_CKOE_BIT] && !hw_standby;
      pll1_on <= frequency_control_reg[`CRC_PLL1_BIT];
      pll2_on <= frequency_control_reg[`CRC_PLL2_BIT];
    end
  end
endmodule // crc_clock_ratio_control
`default_nettype wire

// ---- src/crc_defines.vh ----
// register map, field layout, mode table and timing constants of the clock ratio control
`ifndef CRC_DEFINES_VH
`define CRC_DEFINES_VH
`define CRC_FREQ_CTRL_ADDR 32'hFFC0_0000
`define CRC_STAB_CFG_ADDR 32'hFFC0_0010
`define CRC_CLK_STAT_ADDR 32'hFFC0_0014
`define CRC_CKOE_BIT 11
`define CRC_PLL1_BIT 10
`define CRC_PLL2_BIT 9
`define CRC_CPU_HI 8
`define CRC_CPU_LO 6
`define CRC_BUS_HI 5
`define CRC_BUS_LO 3
`define CRC_PER_HI 2
`define CRC_PER_LO 0
`define CRC_RSVD_MASK 16'h0FFF
`define CRC_INIT_MODE0 16'h0E1A
`define CRC_INIT_MODE1 16'h0E2C
`define CRC_INIT_MODE23 16'h0E13
`define CRC_INIT_MODE45 16'h0E0A
`define CRC_INIT_MODE6 16'h0808
`define CRC_STAB_DEFAULT 16'h0100
`define CRC_POR_CYCLES 4'h4
`endif

// ---- src/crc_mode_decode.v ----
// strap decoder: operating mode to initial register value, halving divider and pll1 factor
`timescale 1ns/100ps
`default_nettype none
`include "crc_defines.vh"
module crc_mode_decode (
  // straps
  input wire [2:0] mode,
  // decoded mode properties
  output reg [15:0] init_value,
  output reg halve_input,
  output reg pll1_x12
);
  always @* begin
    init_value = `CRC_INIT_MODE0;
    halve_input = 1'b0;
    pll1_x12 = 1'b1;
    case (mode)
      3'h0: init_value = `CRC_INIT_MODE0;
      3'h1: init_value = `CRC_INIT_MODE1;
      3'h2: begin
        init_value = `CRC_INIT_MODE23;
        halve_input = 1'b1;
        pll1_x12 = 1'b0;
      end
      3'h3: init_value = `CRC_INIT_MODE23;
      3'h4: begin
        init_value = `CRC_INIT_MODE45;
        halve_input = 1'b1;
        pll1_x12 = 1'b0;
      end
      3'h5: init_value = `CRC_INIT_MODE45;
      default: begin
        init_value = `CRC_INIT_MODE6;
        pll1_x12 = 1'b0;
      end
    endcase
  end
endmodule // crc_mode_decode
`default_nettype wire

// ---- src/crc_ratio_divider.v ----
// divides the reference rate into one-cycle enable pulses for a ratio code
`timescale 1ns/100ps
`default_nettype none
module crc_ratio_divider (
  // clock and reset
  input wire clock,
  input wire rst,
  // reference and control
  input wire ref_en,
  input wire [2:0] code,
  input wire offset_half,
  input wire run,
  // output enable pulse
  output reg tick
);
  reg [2:0] cnt_reg;
  reg [3:0] div;
  always @* begin
    case ({offset_half, code})
      4'h0: div = 4'h1;
      4'h1, 4'h8: div = 4'h2;
      4'h2, 4'h9: div = 4'h3;
      4'h3, 4'hA: div = 4'h4;
      4'h4, 4'hB: div = 4'h6;
      default: div = 4'h8;
    endcase
  end
  // counter keeps its count on a new code but compares against the new divisor, so a ratio change takes effect immediately
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg <= 3'h0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (run && ref_en) begin
        if ({1'b0, cnt_reg} >= div - 4'h1) begin
          cnt_reg <= 3'h0;
          tick <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 3'h1;
        end
      end
    end
  end
endmodule // crc_ratio_divider
`default_nettype wire

// ---- verification/crc_clock_ratio_control_properties.sv ----
// port-level assertions for the clock ratio control
`timescale 1ns/100ps
`default_nettype none
`include "crc_defines.vh"
module crc_clock_ratio_control_properties (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pin and status
  input wire logic hw_standby,
  input wire logic bus_clock_output_pin_oe_n,
  input wire logic bus_clock_pullup_en,
  input wire logic cpu_clock_en,
  input wire logic internal_halt,
  input wire logic pll1_on,
  input wire logic pll2_on,
  input wire logic halving_divider_on,
  input wire logic pll1_mult_x12
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic acc = psel && penable;
  wire logic fa = paddr == `CRC_FREQ_CTRL_ADDR;
  // a frequency write that the block really takes
  wire logic fw = acc && pwrite && fa && pstrb[1:0] == 2'b11 && !internal_halt;
  a_zero_wait: assert property (acc |-> pready)
    else $error("pready low in access phase");
  a_rsvd_read_zero: assert property (acc && !pwrite && fa |-> prdata[15:12] == 4'h0)
    else $error("reserved bits read nonzero");
  a_narrow_write_err: assert property (acc && pwrite && fa && pstrb[1:0] != 2'b11 |-> pslverr)
    else $error("narrow write not refused");
  a_unmapped_err: assert property (acc && !fa && paddr != `CRC_STAB_CFG_ADDR
    && paddr != `CRC_CLK_STAT_ADDR |-> pslverr)
    else $error("unmapped access not refused");
  a_pll1_start_halt: assert property (fw && pwdata[10] && !pll1_on |=> internal_halt)
    else $error("pll1 start did not halt");
  a_halt_stops_cpu: assert property (internal_halt [*3] |-> !cpu_clock_en)
    else $error("cpu pulses during halt");
  a_bus_no_wait: assert property (fw && pll1_on && pwdata[10] && !pll2_on |=> !internal_halt)
    else $error("halt without pll2");
  a_pin_hiz: assert property (fw && !pwdata[11] |-> ##[1:3] bus_clock_output_pin_oe_n)
    else $error("pin still driven");
  a_pullup_hiz: assert property (bus_clock_pullup_en |-> bus_clock_output_pin_oe_n)
    else $error("pull-up while driving");
  a_standby_no_pull: assert property (hw_standby [*2] |-> !bus_clock_pullup_en)
    else $error("pull-up in standby");
  a_mode_fixed: assert property (acc && pwrite |=> $stable(halving_divider_on)
    && $stable(pll1_mult_x12))
    else $error("mode property moved by write");
endmodule // crc_clock_ratio_control_properties
bind crc_clock_ratio_control crc_clock_ratio_control_properties u_chk (.*);
`default_nettype wire

// ---- verification/crc_far_side_model.sv ----
// straps and reference rate pulses on the far side of the clock ratio control
`timescale 1ns/100ps
`default_nettype none
module crc_far_side_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // strap choice
  input wire logic [2:0] mode_sel,
  // pins and rate pulses
  output logic [2:0] mode_strap_pins,
  output logic input_clock_en,
  output logic pll1_out_en
);
  logic [1:0] ph_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      ph_reg <= 2'h0;
    else
      ph_reg <= ph_reg + 2'h1;
  end
  // pll1 output at twice the raw rate keeps the divided counts for ratios 1, 2, 4 and 8 a power of two
  assign pll1_out_en = ph_reg[0];
  assign input_clock_en = ph_reg == 2'h3;
  assign mode_strap_pins = mode_sel;
endmodule // crc_far_side_model
`default_nettype wire

// ---- verification/crc_clock_ratio_control_bench.sv ----
// self-checking bench for the clock ratio control
`timescale 1ns/100ps
`default_nettype none
`include "crc_defines.vh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module crc_clock_ratio_control_bench;
  logic clock, rst, psel, penable, pwrite, hw_standby, er_v, p_pin;
  logic [31:0] paddr, pwdata, rd_v;
  logic [3:0] pstrb;
  logic [2:0] mode_sel;
  wire logic [31:0] prdata;
  wire logic [2:0] mode_strap_pins;
  wire logic pready, pslverr, input_clock_en, pll1_out_en, bus_clock_output_pin_o;
  wire logic bus_clock_output_pin_oe_n, bus_clock_pullup_en, cpu_clock_en, bus_clock_en;
  wire logic periph_clock_en, pll1_on, pll2_on, internal_halt, halving_divider_on, pll1_mult_x12;
  int err_total, n_tests, c_cpu, c_bus, c_per, c_pin, n;
  crc_far_side_model u_far (.*);
  crc_clock_ratio_control DUT (.*);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task give_verdict();
    $display("mismatches %0d comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      err_total++;
      give_verdict();
    end
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask
  task rd(input logic [31:0] a);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
  endtask
  // pulses of each clock enable over 64 cycles
  task cnt();
    c_cpu = 0;
    c_bus = 0;
    c_per = 0;
    c_pin = 0;
    p_pin = bus_clock_output_pin_o;
    repeat (64) begin
      @(posedge clock);
      c_pin += (bus_clock_output_pin_o !== p_pin);
      p_pin = bus_clock_output_pin_o;
      c_cpu += (cpu_clock_en === 1'b1);
      c_bus += (bus_clock_en === 1'b1);
      c_per += (periph_clock_en === 1'b1);
    end
  endtask
  task t_init(input logic [2:0] m, input logic [15:0] v, input logic h, input logic x);
    mode_sel <= m;
    rst <= 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    repeat (6) @(posedge clock);
    rd(`CRC_FREQ_CTRL_ADDR);
    `CHK("init value", v, rd_v[15:0])
    `CHK("halving", h, halving_divider_on)
    `CHK("pll1 x12", x, pll1_mult_x12)
  endtask
  task t_access();
    wr(`CRC_FREQ_CTRL_ADDR, 32'h0000_FE1A);
    rd(`CRC_FREQ_CTRL_ADDR);
    `CHK("reserved", 16'h0E1A, rd_v[15:0])
    apb(1'b1, `CRC_FREQ_CTRL_ADDR, 32'h0000_0E5A, 4'h1);
    `CHK("byte err", 1'b1, er_v)
    rd(`CRC_FREQ_CTRL_ADDR);
    `CHK("byte lost", 16'h0E1A, rd_v[15:0])
    rd(32'hFFC0_0004);
    `CHK("unmapped", 1'b1, er_v)
  endtask
  task t_ratio();
    cnt();
    `CHK("cpu x1", 32, c_cpu)
    `CHK("bus 1/4", 8, c_bus)
    `CHK("per 1/4", 8, c_per)
    `CHK("pin toggles", 8, c_pin)
    wr(`CRC_FREQ_CTRL_ADDR, 32'h0000_0E5A);
    cnt();
    `CHK("cpu 1/2", 16, c_cpu)
  endtask
  task t_pin();
    wr(`CRC_FREQ_CTRL_ADDR, 32'h0000_065A);
    repeat (3) @(posedge clock);
    `CHK("pin hiz", 1'b1, bus_clock_output_pin_oe_n)
    `CHK("pull-up", 1'b1, bus_clock_pullup_en)
    cnt();
    `CHK("cpu kept", 16, c_cpu)
    hw_standby <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK("standby pull", 1'b0, bus_clock_pullup_en)
    hw_standby <= 1'b0;
    wr(`CRC_FREQ_CTRL_ADDR, 32'h0000_0E5A);
    repeat (3) @(posedge clock);
    `CHK("pin driven", 1'b0, bus_clock_output_pin_oe_n)
  endtask
  task t_pll1();
    wr(`CRC_FREQ_CTRL_ADDR, 32'h0000_0A5A);
    cnt();
    `CHK("pll1 off", 1'b0, pll1_on)
    `CHK("cpu raw", 8, c_cpu)
    wr(`CRC_STAB_CFG_ADDR, 32'h0000_FFF0);
    wr(`CRC_FREQ_CTRL_ADDR, 32'h0000_0E5A);
    @(posedge clock);
    `CHK("halt", 1'b1, internal_halt)
    for (n = 0; n < 400; n++) begin
      @(posedge clock);
      if (internal_halt === 1'b0) break;
    end
    if (n == 400) begin
      err_total++;
      give_verdict();
    end
    `CHK("halt long", 1'b1, n >= 16)
  endtask
  task t_pll2();
    wr(`CRC_FREQ_CTRL_ADDR, 32'h0000_0C5A);
    repeat (2) @(posedge clock);
    `CHK("pll2 off", 1'b0, pll2_on)
    wr(`CRC_FREQ_CTRL_ADDR, 32'h0000_0C63);
    @(posedge clock);
    `CHK("no wait", 1'b0, internal_halt)
    rd(`CRC_FREQ_CTRL_ADDR);
    `CHK("bus field", 16'h0C63, rd_v[15:0])
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    hw_standby = 1'b0;
    mode_sel = 3'h0;
    t_init(3'h0, 16'h0E1A, 1'b0, 1'b1);
    t_access();
    t_ratio();
    t_pin();
    t_pll1();
    t_pll2();
    t_init(3'h4, 16'h0E0A, 1'b1, 1'b0);
    t_init(3'h1, 16'h0E2C, 1'b0, 1'b1);
    t_init(3'h2, 16'h0E13, 1'b1, 1'b0);
    t_init(3'h3, 16'h0E13, 1'b0, 1'b1);
    t_init(3'h5, 16'h0E0A, 1'b0, 1'b1);
    t_init(3'h6, 16'h0808, 1'b0, 1'b0);
    give_verdict();
  end
endmodule // crc_clock_ratio_control_bench
`default_nettype wire
